/* logic/rglc_regs.sv */
// Record gain, mic bias and level control register bank with AXI4-Lite slave
//
// Overview of operation
// - Right diff boost: mute, unity, +20 dB
// - Right aux gain: mute, -12..+6 dB
// - Diff volume code: -12 dB, 0.75 dB/code
// - Diff enable picks pair or single-ended bypass
// - Bias bit 3 selects high-performance current
// - Bias bit 2 selects 0.90 or 0.65 supply
// - Bias bit 0 turns bias output on
// - Level control off: volume ramps over slew time
// - Max-gain field caps level control gain
// - Channel select: off, right, left, stereo, processor
// - Single channel senses one; stereo tracks louder
// - Processor mode takes gain from external source
// - Hold time before raising gain, doubling per code
// - Target field sets level, -28.5 dB, 1.5 dB/code
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module rglc_regs
    import rglc_pkg::*;
#(
    parameter int SLEW_STEP_CYC = RGLC_SLEW_STEP_CYC,
    parameter int HOLD_BASE_CYC = RGLC_HOLD_BASE_CYC
) (
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write address and data
    input  wire logic [RGLC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [RGLC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Level control engine side
    input  wire logic [5:0]             left_level,
    input  wire logic [5:0]             right_level,
    input  wire logic [5:0]             level_gain_req,
    input  wire logic [5:0]             proc_gain_left,
    input  wire logic [5:0]             proc_gain_right,
    input  wire logic                   level_fall,
    // Analog controls
    output logic [1:0]                  right_diff_boost,
    output logic [2:0]                  right_aux_gain,
    output logic [5:0]                  left_gain_applied,
    output logic [5:0]                  right_gain_applied,
    output logic                        left_diff_unmute,
    output logic                        right_diff_unmute,
    output logic                        left_diff_enable,
    output logic                        right_diff_enable,
    output logic                        bias_high_perf,
    output logic                        bias_voltage_select,
    output logic                        bias_output_enable,
    // Level control parameters and status
    output logic [2:0]                  level_channel_select,
    output logic [3:0]                  level_target,
    output logic [5:0]                  sense_level,
    output logic                        gain_raise_ok
);
    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0]  rmix_r;
    logic [7:0]  vol_r [2];
    logic [7:0]  bias_r;
    logic [7:0]  lvla_r;
    logic [7:0]  lvlb_r;

    // Address match on the word index
    function automatic logic idx_hit(input logic [RGLC_ADDR_W-1:0] a,
                                     input logic [15:0] idx);
        idx_hit = (a[RGLC_ADDR_W-1:2] == idx);
    endfunction

    // Clamp a gain code to the programmed ceiling
    function automatic logic [5:0] cap_gain(input logic [5:0] g,
                                            input logic [2:0] mx);
        logic [5:0] lim;
        lim = 6'(mx * RGLC_MAX_STEP);
        cap_gain = (g > lim) ? lim : g;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    logic                   aw_held_r;
    logic                   w_held_r;
    logic [RGLC_ADDR_W-1:0] awaddr_r;
    logic [7:0]             wbyte_r;
    logic                   wlane_r;
    logic                   wr_go;
    logic                   wr_hit;

    assign wr_go  = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit = idx_hit(awaddr_r, RGLC_IDX_RMIX) || idx_hit(awaddr_r, RGLC_IDX_LVOL)
                 || idx_hit(awaddr_r, RGLC_IDX_RVOL) || idx_hit(awaddr_r, RGLC_IDX_BIAS)
                 || idx_hit(awaddr_r, RGLC_IDX_LVLA) || idx_hit(awaddr_r, RGLC_IDX_LVLB);

    // Address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            awaddr_r      <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !wr_go;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
        end
    end

    // Data capture; only byte lane 0 holds register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r     <= 1'b0;
            wbyte_r      <= '0;
            wlane_r      <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !wr_go;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                wbyte_r  <= s_axi_wdata[7:0];
                wlane_r  <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response after both halves have arrived
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RGLC_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RGLC_RESP_OKAY : RGLC_RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register updates; reserved bits dropped, reserved codes keep old value
    logic wr_en;
    assign wr_en = wr_go && wlane_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rmix_r <= RGLC_RST_REG;
        end else if (wr_en && idx_hit(awaddr_r, RGLC_IDX_RMIX)) begin
            rmix_r[RGLC_AUX_LSB +: 3] <= wbyte_r[RGLC_AUX_LSB +: 3];
            if (wbyte_r[RGLC_BOOST_LSB +: 2] != RGLC_BOOST_RSV) begin
                rmix_r[RGLC_BOOST_LSB +: 2] <= wbyte_r[RGLC_BOOST_LSB +: 2];
            end
        end
    end

    // Volume, mute and pair enable per channel (0 left, 1 right)
    generate
        for (genvar c = 0; c < 2; c++) begin : g_vol
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    vol_r[c] <= RGLC_RST_REG;
                end else if (wr_en && idx_hit(awaddr_r,
                             (c == 0) ? RGLC_IDX_LVOL : RGLC_IDX_RVOL)) begin
                    vol_r[c] <= wbyte_r;
                end
            end
        end
    endgenerate

    // Mic bias: bits 3, 2 and 0 only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bias_r <= RGLC_RST_REG;
        end else if (wr_en && idx_hit(awaddr_r, RGLC_IDX_BIAS)) begin
            bias_r <= '0;
            bias_r[RGLC_PERF_BIT] <= wbyte_r[RGLC_PERF_BIT];
            bias_r[RGLC_VSEL_BIT] <= wbyte_r[RGLC_VSEL_BIT];
            bias_r[RGLC_BEN_BIT]  <= wbyte_r[RGLC_BEN_BIT];
        end
    end

    // Level control config A; select codes above processor mode ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvla_r <= RGLC_RST_REG;
        end else if (wr_en && idx_hit(awaddr_r, RGLC_IDX_LVLA)) begin
            lvla_r[7:RGLC_MAX_LSB] <= wbyte_r[7:RGLC_MAX_LSB];
            if (wbyte_r[RGLC_SEL_LSB +: 3] <= RGLC_SEL_PROC) begin
                lvla_r[RGLC_SEL_LSB +: 3] <= wbyte_r[RGLC_SEL_LSB +: 3];
            end
        end
    end

    // Level control config B: hold and target; the advised hold and
    // target ranges are not enforced, any code is accepted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvlb_r <= RGLC_RST_REG;
        end else if (wr_en && idx_hit(awaddr_r, RGLC_IDX_LVLB)) begin
            lvlb_r <= wbyte_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel, one cycle from address to data
    logic [7:0] rd_byte;
    logic       rd_hit;

    always_comb begin
        rd_byte = '0;
        rd_hit  = 1'b1;
        if (idx_hit(s_axi_araddr, RGLC_IDX_RMIX)) begin
            rd_byte = rmix_r;
        end else if (idx_hit(s_axi_araddr, RGLC_IDX_LVOL)) begin
            rd_byte = vol_r[0];
        end else if (idx_hit(s_axi_araddr, RGLC_IDX_RVOL)) begin
            rd_byte = vol_r[1];
        end else if (idx_hit(s_axi_araddr, RGLC_IDX_BIAS)) begin
            rd_byte = bias_r;
        end else if (idx_hit(s_axi_araddr, RGLC_IDX_LVLA)) begin
            rd_byte = lvla_r;
        end else if (idx_hit(s_axi_araddr, RGLC_IDX_LVLB)) begin
            rd_byte = lvlb_r;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read response; upper bits read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RGLC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_hit ? RGLC_RESP_OKAY : RGLC_RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slew step divider; the step period doubles per slew code
    logic [1:0]  slew_code;
    logic [2:0]  sel;
    logic [31:0] slew_cnt_r;
    logic [31:0] slew_top;
    logic        step_en_r;

    assign slew_code = lvla_r[RGLC_SLEW_LSB +: 2];
    assign sel       = lvla_r[RGLC_SEL_LSB +: 3];
    assign slew_top  = (32'(SLEW_STEP_CYC) << slew_code) - 32'h00000001;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slew_cnt_r <= '0;
            step_en_r  <= 1'b0;
        end else if (slew_cnt_r >= slew_top) begin
            slew_cnt_r <= '0;
            step_en_r  <= 1'b1;
        end else begin
            slew_cnt_r <= slew_cnt_r + 32'h00000001;
            step_en_r  <= 1'b0;
        end
    end

    // Ramped manual volume per channel
    logic [5:0] ramp_lvl [2];

    generate
        for (genvar c = 0; c < 2; c++) begin : g_ramp
            rglc_ramp #(
                .WIDTH (6)
            ) u_ramp (
                .aclk    (aclk),
                .aresetn (aresetn),
                .step_en (step_en_r),
                .bypass  (slew_code == RGLC_SLEW_NONE),
                .target  (vol_r[c][RGLC_VOL_LSB +: 6]),
                .level_r (ramp_lvl[c])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Hold timer: after a level fall, block gain increases for the hold time
    logic [31:0] hold_cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_cnt_r    <= '0;
            gain_raise_ok <= 1'b1;
        end else if (level_fall) begin
            hold_cnt_r    <= 32'(HOLD_BASE_CYC) << lvlb_r[RGLC_HOLD_LSB +: 4];
            gain_raise_ok <= 1'b0;
        end else if (hold_cnt_r > 32'h00000001) begin
            hold_cnt_r <= hold_cnt_r - 32'h00000001;
        end else begin
            hold_cnt_r    <= '0;
            gain_raise_ok <= 1'b1;
        end
    end

    // Loop gain: capped, and may only rise once the hold has run out
    logic [5:0] loop_gain_r;
    logic [5:0] loop_want;

    assign loop_want = cap_gain(level_gain_req, lvla_r[RGLC_MAX_LSB +: 3]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_gain_r <= '0;
        end else if ((loop_want <= loop_gain_r) || gain_raise_ok) begin
            loop_gain_r <= loop_want;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gain source per channel and sensed level by channel selection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left_gain_applied  <= '0;
            right_gain_applied <= '0;
            sense_level        <= '0;
        end else begin
            left_gain_applied  <= ramp_lvl[0];
            right_gain_applied <= ramp_lvl[1];
            sense_level        <= '0;
            case (sel)
                RGLC_SEL_RIGHT: begin
                    right_gain_applied <= loop_gain_r;
                    sense_level        <= right_level;
                end
                RGLC_SEL_LEFT: begin
                    left_gain_applied <= loop_gain_r;
                    sense_level       <= left_level;
                end
                RGLC_SEL_STEREO: begin
                    left_gain_applied  <= loop_gain_r;
                    right_gain_applied <= loop_gain_r;
                    sense_level <= (left_level > right_level) ? left_level : right_level;
                end
                RGLC_SEL_PROC: begin
                    left_gain_applied  <= proc_gain_left;
                    right_gain_applied <= proc_gain_right;
                end
                default: begin
                    sense_level <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Static control outputs, registered copies of the fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            right_diff_boost     <= '0;
            right_aux_gain       <= '0;
            left_diff_unmute     <= 1'b0;
            right_diff_unmute    <= 1'b0;
            left_diff_enable     <= 1'b0;
            right_diff_enable    <= 1'b0;
            bias_high_perf       <= 1'b0;
            bias_voltage_select  <= 1'b0;
            bias_output_enable   <= 1'b0;
            level_channel_select <= RGLC_SEL_OFF;
            level_target         <= '0;
        end else begin
            right_diff_boost     <= rmix_r[RGLC_BOOST_LSB +: 2];
            right_aux_gain       <= rmix_r[RGLC_AUX_LSB +: 3];
            left_diff_unmute     <= vol_r[0][RGLC_UNMUTE_BIT];
            right_diff_unmute    <= vol_r[1][RGLC_UNMUTE_BIT];
            left_diff_enable     <= vol_r[0][RGLC_DIFF_BIT];
            right_diff_enable    <= vol_r[1][RGLC_DIFF_BIT];
            bias_high_perf       <= bias_r[RGLC_PERF_BIT];
            bias_voltage_select  <= bias_r[RGLC_VSEL_BIT];
            bias_output_enable   <= bias_r[RGLC_BEN_BIT];
            level_channel_select <= sel;
            level_target         <= lvlb_r[RGLC_TARG_LSB +: 4];
        end
    end
endmodule

/* logic/rglc_pkg.sv */
// Shared constants for the record gain and level control register bank
package rglc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] RGLC_IDX_RMIX    = 16'h400D;
    localparam logic [15:0] RGLC_IDX_LVOL    = 16'h400E;
    localparam logic [15:0] RGLC_IDX_RVOL    = 16'h400F;
    localparam logic [15:0] RGLC_IDX_BIAS    = 16'h4010;
    localparam logic [15:0] RGLC_IDX_LVLA    = 16'h4011;
    localparam logic [15:0] RGLC_IDX_LVLB    = 16'h4012;
    localparam int          RGLC_ADDR_W      = 18;
    // Field positions
    localparam int RGLC_BOOST_LSB  = 3;
    localparam int RGLC_AUX_LSB    = 0;
    localparam int RGLC_VOL_LSB    = 2;
    localparam int RGLC_UNMUTE_BIT = 1;
    localparam int RGLC_DIFF_BIT   = 0;
    localparam int RGLC_PERF_BIT   = 3;
    localparam int RGLC_VSEL_BIT   = 2;
    localparam int RGLC_BEN_BIT    = 0;
    localparam int RGLC_SLEW_LSB   = 6;
    localparam int RGLC_MAX_LSB    = 3;
    localparam int RGLC_SEL_LSB    = 0;
    localparam int RGLC_HOLD_LSB   = 4;
    localparam int RGLC_TARG_LSB   = 0;
    // Reset values (all fields come up at code zero)
    localparam logic [7:0] RGLC_RST_REG  = 8'h00;
    localparam logic [1:0] RGLC_BOOST_RSV = 2'h3;
    // Level control channel selection codes
    localparam logic [2:0] RGLC_SEL_OFF    = 3'h0;
    localparam logic [2:0] RGLC_SEL_RIGHT  = 3'h1;
    localparam logic [2:0] RGLC_SEL_LEFT   = 3'h2;
    localparam logic [2:0] RGLC_SEL_STEREO = 3'h3;
    localparam logic [2:0] RGLC_SEL_PROC   = 3'h4;
    // Slew code meaning no ramp
    localparam logic [1:0] RGLC_SLEW_NONE  = 2'h3;
    // Volume code scale: one code per 0.75 dB, 6 dB is eight codes
    localparam int         RGLC_MAX_STEP   = 8;
    localparam int         RGLC_VOL_CODES  = 64;
    // Timing at the 40 MHz system clock
    localparam int  RGLC_CLK_KHZ       = 40000;
    localparam real RGLC_SLEW_BASE_MS  = 24.0;
    localparam real RGLC_HOLD_BASE_MS  = 2.67;
    localparam int  RGLC_SLEW_STEP_CYC =
        int'(RGLC_SLEW_BASE_MS * RGLC_CLK_KHZ / RGLC_VOL_CODES);
    localparam int  RGLC_HOLD_BASE_CYC = int'(RGLC_HOLD_BASE_MS * RGLC_CLK_KHZ);
    // AXI responses
    localparam logic [1:0] RGLC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RGLC_RESP_DECERR = 2'h3;
endpackage

/* logic/rglc_ramp.sv */
// Volume ramp that walks the applied code one step per enable toward a target
`timescale 1ns/100ps
module rglc_ramp #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Control
    input  wire logic             step_en,
    input  wire logic             bypass,
    input  wire logic [WIDTH-1:0] target,
    // Result
    output logic      [WIDTH-1:0] level_r
);
    logic [WIDTH-1:0] level_nxt;

    // One code per step so the audible change spreads over the slew time
    always_comb begin
        level_nxt = level_r;
        if (bypass) begin
            level_nxt = target;
        end else if (step_en && (level_r < target)) begin
            level_nxt = level_r + WIDTH'(1);
        end else if (step_en && (level_r > target)) begin
            level_nxt = level_r - WIDTH'(1);
        end
    end

    // Applied level register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_r <= '0;
        end else begin
            level_r <= level_nxt;
        end
    end
endmodule

/* testbench/rglc_regs_chk.sv */
// Concurrent checks on the register bank bus and control outputs
`timescale 1ns/100ps
module rglc_regs_chk
    import rglc_pkg::*;
(
    // Clock and reset
    input logic        aclk,
    input logic        aresetn,
    // Bus handshakes
    input logic        s_axi_awready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // Level side
    input logic [1:0]  right_diff_boost,
    input logic [2:0]  level_channel_select,
    input logic [5:0]  left_level,
    input logic [5:0]  right_level,
    input logic [5:0]  sense_level,
    input logic [5:0]  proc_gain_left,
    input logic [5:0]  left_gain_applied
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped early");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while response pending");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data changed early");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_boost_legal: assert property (right_diff_boost != RGLC_BOOST_RSV)
        else $error("reserved boost code applied");
    a_sel_legal: assert property (level_channel_select <= RGLC_SEL_PROC)
        else $error("reserved select code applied");
    a_sense_right: assert property (level_channel_select == RGLC_SEL_RIGHT
        |-> sense_level == $past(right_level)) else $error("right sense wrong");
    a_sense_left: assert property (level_channel_select == RGLC_SEL_LEFT
        |-> sense_level == $past(left_level)) else $error("left sense wrong");
    a_sense_stereo: assert property (level_channel_select == RGLC_SEL_STEREO
        |-> sense_level == ($past(left_level) > $past(right_level) ? $past(left_level)
        : $past(right_level))) else $error("stereo sense not the louder");
    a_proc_gain: assert property (level_channel_select == RGLC_SEL_PROC
        |-> left_gain_applied == $past(proc_gain_left)) else $error("processor gain");
    // Main scenarios reached
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_stereo: cover property (level_channel_select == RGLC_SEL_STEREO);
    c_proc: cover property (level_channel_select == RGLC_SEL_PROC);
endmodule
bind rglc_regs rglc_regs_chk u_chk (.*);

/* testbench/rglc_regs_tb_top.sv */
// Self-checking bench for the record gain register bank
`timescale 1ns/100ps
module rglc_regs_tb_top;
    import rglc_pkg::*;
    localparam logic [17:0] BASE = 18'h10034;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, level_target;
    logic [1:0]  s_axi_bresp, s_axi_rresp, right_diff_boost;
    logic [2:0]  right_aux_gain, level_channel_select;
    logic [5:0]  left_level, right_level, level_gain_req, proc_gain_left, proc_gain_right;
    logic [5:0]  left_gain_applied, right_gain_applied, sense_level;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, level_fall, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, left_diff_unmute, right_diff_unmute;
    logic        left_diff_enable, right_diff_enable, bias_high_perf, gain_raise_ok;
    logic        bias_voltage_select, bias_output_enable;
    logic [7:0]  m [7];
    integer      seed = 32'hAFE4;
    int          errors = 0, n_checks = 0, k, e, tgt, i;
    rglc_regs #(.SLEW_STEP_CYC(4), .HOLD_BASE_CYC(8)) uut (.*);
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, level_fall} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_wstrb, left_level, right_level, level_gain_req} = '0;
        {proc_gain_left, proc_gain_right} = '0;
        for (int j = 0; j < 7; j++) m[j] = 8'h00;
    end
    // 40 MHz clock
    always #12.5 aclk = ~aclk;
    // Engine inputs wander every cycle so the level logic sees real traffic
    always @(posedge aclk) begin
        {left_level, right_level, level_gain_req} <= 18'($random(seed));
        {proc_gain_left, proc_gain_right} <= 12'($random(seed));
    end
    ////////////////////////////////////////////////////////////////////////////
    // Register model: reserved bits drop, reserved codes keep the old field
    function automatic logic [7:0] nv(int r, logic [7:0] o, logic [7:0] d);
        if (r == 0) return {3'h0, d[4:3] == 2'h3 ? o[4:3] : d[4:3], d[2:0]};
        if (r == 3) return d & 8'h0D;
        if (r == 4 && d[2:0] > 3'h4) return {d[7:3], o[2:0]};
        return d;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic guard;
        if (k >= 2000) begin
            errors++;
            results;
        end
    endtask
    // Bus master: address and data offered together, each released when taken
    task automatic wr(input int r, input logic [7:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= BASE + 18'(4 * r);
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid | s_axi_wvalid) !== 1'b0 && k < 2000);
        while (s_axi_bvalid !== 1'b1 && k < 2000) begin
            @(posedge aclk);
            k++;
        end
        guard;
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), r < 6 ? 32'h0 : 32'h3);
        if (r < 6 && s[0]) m[r] = nv(r, m[r], d);
    endtask
    task automatic rd(input int r);
        @(posedge aclk);
        s_axi_araddr <= BASE + 18'(4 * r);
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && k < 2000);
        guard;
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, r < 6 ? {24'h0, m[r]} : 32'h0);
        check(32'(s_axi_rresp), r < 6 ? 32'h0 : 32'h3);
        check({13'h0, right_diff_boost, right_aux_gain, left_diff_unmute, left_diff_enable,
               right_diff_unmute, right_diff_enable, bias_high_perf, bias_voltage_select,
               bias_output_enable, level_channel_select, level_target},
              {13'h0, m[0][4:0], m[1][1:0], m[2][1:0], m[3][3:2], m[3][0], m[4][2:0],
               m[5][3:0]});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, every select code, random traffic, timing
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int r = 0; r < 6; r++) rd(r);
        for (int n = 0; n < 48; n++) begin
            i = n < 8 ? 4 : int'($unsigned($random(seed)) % 7);
            wr(i, n < 8 ? {5'h18, 3'(n)} : 8'($random(seed)),
               n < 8 ? 4'hF : 4'($random(seed)));
            rd(i);
        end
        // Slew codes: up and down ramps, then an instant step
        wr(4, 8'hC0, 4'hF);
        wr(1, 8'h00, 4'hF);
        tgt = 40;
        for (int s = 0; s < 4; s++) begin
            wr(4, {2'(s), 6'h0}, 4'hF);
            wr(1, {6'(tgt), 2'h1}, 4'hF);
            e = s == 3 ? 0 : 40 * (4 << s);
            for (k = 0; left_gain_applied !== 6'(tgt) && k < 2000; k++) @(posedge aclk);
            guard;
            check(32'(k + (4 << s) >= e && k <= e + 3), 32'h1);
            tgt = 40 - tgt;
        end
        check(32'(right_gain_applied), 32'(m[2][7:2]));
        // Hold time doubles per code, advised codes only
        for (int h = 3; h < 6; h++) begin
            wr(5, {4'(h), 4'hA}, 4'hF);
            @(posedge aclk);
            level_fall <= 1'b1;
            @(posedge aclk);
            level_fall <= 1'b0;
            k = 0;
            do begin
                @(posedge aclk);
                k++;
            end while (gain_raise_ok !== 1'b1 && k < 2000);
            guard;
            check(32'(k + 3 >= (8 << h) && k <= (8 << h) + 3), 32'h1);
        end
        results;
    end
endmodule
